// file: gdpsc_top.sv
`timescale 1ns/1ps
// Summary of operation
// - Enable high keeps bias rail enabled and gates live while fault free; pump follows supply level.
// - Enable falling forces all gate outputs low within 100 ns.
// - Standby or sleep only after enable low 1 ms, except standby entered straight from power-up with enable low; short pulses ignored.
// - Standby keeps gate-bias regulator and charge pump off.
// - Enable rising edge clears fault latch only if fault has gone.
// - Sleep-select set sends qualified low period to sleep, else standby.
// - Error flag pin low while fault latched until cleared by enable edge.
// - Error flag held low after power-up until logic-supply step done.
// - Wake from sleep on resume rising edge after long enough low.
// - Logic-supply regulator on in every state except sleep.
// - Below pump threshold the pump feeds bias regulator, else main supply.
// - Above 13.5V pump off and bypassed, regulator fed from main supply.
// - Bias-ready flag asserts when gate-bias rail reaches ready level.
// - Bias state moves to active after 15 ms time-out anyway.
// - Sleep is entered even with a fault still active.
module gdpsc_top #(
   parameter int QUAL_CYC = gdpsc_pkg::QUAL_CYC,     // Enable-low qualify
   parameter int BIAS_CYC = gdpsc_pkg::BIAS_TMO_CYC  // Bias time-out
) (
   input  wire logic       clk_i,             // 40 MHz clock
   input  wire logic       reset_n_i,         // Sync reset, active low
   input  wire logic       drive_en_i,        // Drive-enable pin
   input  wire logic       resume_i,          // Resume (wake) pin
   input  wire logic       sleep_sel_i,       // Low-power select bit
   input  wire logic [2:0] pwm_hi_i,          // High-side PWM, phases a-c
   input  wire logic [2:0] pwm_lo_i,          // Low-side PWM, phases a-c
   input  wire logic       fault_cond_i,      // Any fault condition present
   input  wire logic       below_pump_th_i,   // Main supply below pump start
   input  wire logic       above_bypass_i,    // Main supply above 13.5V
   input  wire logic       bias_rail_ok_i,    // Gate-bias rail above ready
   input  wire logic       logic_rail_ok_i,   // Logic supply in regulation
   input  wire logic       err_flag_i,        // Error flag pin level
   output logic            err_flag_o,        // Error flag pin drive value
   output logic            err_flag_oe_o,     // Error flag pulled low
   output logic [2:0]      high_gate_out_o,   // High-side gates a-c
   output logic [2:0]      low_gate_out_o,    // Low-side gates a-c
   output logic            pump_en_o,         // Charge pump enable
   output logic            pump_bypass_o,     // Regulator fed from main
   output logic            bias_reg_en_o,     // Gate-bias regulator enable
   output logic            logic_reg_en_o,    // Logic-supply regulator on
   output logic            bias_ready_flag_o  // Gate-bias rail ready
);

   gdpsc_pkg::gdpsc_state_e state_ff;
   gdpsc_pkg::gdpsc_state_e nxt_state;
   logic                    en_prev_ff;
   logic                    resume_prev_ff;
   logic                    fault_latch_ff;
   logic                    nxt_fault_latch;

   gdpsc_tmr_if qual_if ();
   gdpsc_tmr_if bias_if ();
   gdpsc_tmr_if wake_if ();

   // Decode
   wire en_rise     = drive_en_i && !en_prev_ff;
   wire resume_rise = resume_i && !resume_prev_ff;
   wire qual_done   = qual_if.done;
   wire bias_done   = bias_if.done;
   wire wake_ok     = resume_rise && wake_if.done;
   wire in_bias     = (state_ff == gdpsc_pkg::ST_BIAS);
   wire in_active   = (state_ff == gdpsc_pkg::ST_ACTIVE);
   wire in_standby  = (state_ff == gdpsc_pkg::ST_STANDBY);
   wire in_sleep    = (state_ff == gdpsc_pkg::ST_SLEEP);
   wire powering_up = (state_ff == gdpsc_pkg::ST_POR)
                   || (state_ff == gdpsc_pkg::ST_LOGIC);
   wire bias_on     = in_bias || in_active;
   wire fault_any   = fault_latch_ff || fault_cond_i;
   wire gdpsc_pkg::gdpsc_state_e lp_target =
      sleep_sel_i ? gdpsc_pkg::ST_SLEEP : gdpsc_pkg::ST_STANDBY;
   // gates live only while enabled and fault free
   wire gate_live   = drive_en_i && in_active && !fault_any;
   wire pump_w      = bias_on && below_pump_th_i && !above_bypass_i;
   wire bypass_w    = bias_on && !pump_w;

   // qualify counter restarts on enable high
   assign qual_if.clr = drive_en_i;
   assign qual_if.run = !drive_en_i;
   assign bias_if.clr = !in_bias;
   assign bias_if.run = in_bias;
   // Resume low time measured while the pin is low
   assign wake_if.clr = resume_i;
   assign wake_if.run = !resume_i;

   gdpsc_timer #(.LIMIT(QUAL_CYC)) u_qual (
      .clk_i     (clk_i),
      .reset_n_i (reset_n_i),
      .t         (qual_if.tmr)
   );

   gdpsc_timer #(.LIMIT(BIAS_CYC)) u_bias (
      .clk_i     (clk_i),
      .reset_n_i (reset_n_i),
      .t         (bias_if.tmr)
   );

   gdpsc_timer #(.LIMIT(gdpsc_pkg::RESUME_LOW_CYC)) u_wake (
      .clk_i     (clk_i),
      .reset_n_i (reset_n_i),
      .t         (wake_if.tmr)
   );

   // clear only when condition is gone; a new fault wins
   assign nxt_fault_latch = fault_cond_i
                         || (fault_latch_ff && !en_rise);

   always_comb begin
      nxt_state = state_ff;
      case (state_ff)
         gdpsc_pkg::ST_POR: begin
            nxt_state = gdpsc_pkg::ST_LOGIC;
         end
         gdpsc_pkg::ST_LOGIC: begin
            // Sleep select ignored here; enable picks bias or standby once the logic rail regulates
            if (logic_rail_ok_i) begin
               nxt_state = drive_en_i ? gdpsc_pkg::ST_BIAS
                                      : gdpsc_pkg::ST_STANDBY;
            end
         end
         gdpsc_pkg::ST_BIAS: begin
            if (qual_done) begin
               nxt_state = lp_target;
            end else if (bias_rail_ok_i || bias_done) begin
               nxt_state = gdpsc_pkg::ST_ACTIVE;
            end
         end
         gdpsc_pkg::ST_ACTIVE: begin
            if (qual_done) begin
               nxt_state = lp_target;
            end
         end
         gdpsc_pkg::ST_STANDBY: begin
            if (drive_en_i) begin
               nxt_state = gdpsc_pkg::ST_BIAS;
            end else if (sleep_sel_i && qual_done) begin
               nxt_state = gdpsc_pkg::ST_SLEEP;
            end
         end
         gdpsc_pkg::ST_SLEEP: begin
            if (wake_ok) begin
               nxt_state = gdpsc_pkg::ST_POR;
            end
         end
         default: begin
            nxt_state = gdpsc_pkg::RST_STATE;
         end
      endcase
   end

   always_ff @(posedge clk_i) begin
      if (!reset_n_i) begin
         state_ff       <= gdpsc_pkg::RST_STATE;
         en_prev_ff     <= 1'b0;
         resume_prev_ff <= 1'b0;
         fault_latch_ff <= 1'b0;
      end else begin
         state_ff       <= nxt_state;
         en_prev_ff     <= drive_en_i;
         resume_prev_ff <= resume_i;
         fault_latch_ff <= nxt_fault_latch;
      end
   end

   // Outputs registered; one cycle stays inside the 100 ns budget
   always_ff @(posedge clk_i) begin
      if (!reset_n_i) begin
         high_gate_out_o   <= gdpsc_pkg::GATES_OFF;
         low_gate_out_o    <= gdpsc_pkg::GATES_OFF;
         err_flag_oe_o     <= 1'b1;
         pump_en_o         <= 1'b0;
         pump_bypass_o     <= 1'b0;
         bias_reg_en_o     <= 1'b0;
         logic_reg_en_o    <= 1'b1;
         bias_ready_flag_o <= 1'b0;
      end else begin
         // gates low the cycle after enable falls
         high_gate_out_o   <= gate_live ? pwm_hi_i : gdpsc_pkg::GATES_OFF;
         low_gate_out_o    <= gate_live ? pwm_lo_i : gdpsc_pkg::GATES_OFF;
         // pin low on fault or until ready
         err_flag_oe_o     <= nxt_fault_latch || powering_up;
         // bias and pump off outside bias and active
         pump_en_o         <= pump_w;
         pump_bypass_o     <= bypass_w;
         bias_reg_en_o     <= bias_on;
         // logic supply off in sleep only
         logic_reg_en_o    <= !in_sleep;
         // ready flag follows the rail comparator
         bias_ready_flag_o <= bias_on && bias_rail_ok_i;
      end
   end

   // Open-drain pin only ever pulls low
   assign err_flag_o = 1'b0;

   default clocking cb @(posedge clk_i);
   endclocking
   default disable iff (!reset_n_i);

   a_gate_off_fast: assert property (
      !drive_en_i |=> (high_gate_out_o == 3'h0 && low_gate_out_o == 3'h0))
      else $error("gates not off after enable low");

   a_lowpwr_qualified: assert property (
      (bias_on && !(nxt_state == gdpsc_pkg::ST_BIAS
                    || nxt_state == gdpsc_pkg::ST_ACTIVE))
      |-> qual_done)
      else $error("low-power entry without qualification");

   a_standby_bias_off: assert property (
      in_standby [*2] |-> (!bias_reg_en_o && !pump_en_o))
      else $error("bias or pump on in standby");

   a_fault_clear: assert property (
      (fault_latch_ff && en_rise && !fault_cond_i) |=> !fault_latch_ff)
      else $error("fault latch not cleared");

   a_fault_hold: assert property (
      (fault_latch_ff && !en_rise) |=> fault_latch_ff)
      else $error("fault latch dropped without enable edge");

   a_sleep_select: assert property (
      (in_active && qual_done) |=>
      (state_ff == ($past(sleep_sel_i) ? gdpsc_pkg::ST_SLEEP
                                       : gdpsc_pkg::ST_STANDBY)))
      else $error("wrong low-power target");

   a_flag_on_fault: assert property (
      (fault_cond_i ##1 !en_rise) |-> err_flag_oe_o [*2])
      else $error("error flag not low on fault");

   a_flag_hold: assert property (
      (fault_latch_ff && !en_rise) |=> err_flag_oe_o)
      else $error("error flag released while latched");

   a_flag_powerup: assert property (
      powering_up |=> err_flag_oe_o)
      else $error("error flag released during power-up");

   a_wake_only_qual: assert property (
      (in_sleep && !wake_ok) |=> in_sleep)
      else $error("left sleep without qualified wake");

   a_logic_reg_sleep: assert property (
      in_sleep |=> !logic_reg_en_o)
      else $error("logic supply on in sleep");

   a_bias_timeout: assert property (
      (in_bias && bias_done && !qual_done) |=> in_active)
      else $error("bias time-out did not reach active");

   a_gates_follow: assert property (
      (drive_en_i && in_active && !fault_any) |=>
      (high_gate_out_o == $past(pwm_hi_i)
       && low_gate_out_o == $past(pwm_lo_i)))
      else $error("gates do not follow pwm while enabled");

   a_active_rails_on: assert property (
      in_active |=> (bias_reg_en_o && logic_reg_en_o))
      else $error("rail off while active");

   a_active_hold: assert property (
      (in_active && !qual_done) |=> in_active)
      else $error("left active without qualified low");

   a_pump_low_supply: assert property (
      (bias_on && below_pump_th_i && !above_bypass_i)
      |=> (pump_en_o && !pump_bypass_o))
      else $error("pump not feeding regulator at low supply");

   a_pump_bypassed: assert property (
      (bias_on && above_bypass_i) |=> (!pump_en_o && pump_bypass_o))
      else $error("pump not bypassed at high supply");

   a_ready_flag: assert property (
      bias_on |=> (bias_ready_flag_o == $past(bias_rail_ok_i)))
      else $error("bias ready flag does not follow rail");

   a_sleep_fault: assert property (
      (in_active && qual_done && sleep_sel_i && fault_any) |=> in_sleep)
      else $error("fault blocked sleep entry");

   a_qual_restart: assert property (
      drive_en_i |=> !qual_done)
      else $error("qualify count not restarted by enable");

   a_logic_reg_on: assert property (
      !in_sleep |=> logic_reg_en_o)
      else $error("logic supply off outside sleep");

   c_short_pulse_clear: cover property (
      fault_latch_ff && en_rise && !fault_cond_i && in_active);
   c_sleep_entry: cover property (in_active ##1 in_sleep);
   c_wake: cover property (in_sleep && wake_ok);
   c_flag_low_seen: cover property (err_flag_oe_o && !err_flag_i);
   c_bias_timeout: cover property (in_bias && bias_done && !bias_rail_ok_i);

endmodule

// file: gdpsc_pkg.sv
package gdpsc_pkg;

   // Clock
   localparam int CLK_HZ = 40_000_000;
   localparam int CLK_NS = 25;

   // Gate shut-off limit after the enable falls
   localparam int GATE_OFF_NS  = 100;
   localparam int GATE_OFF_CYC = GATE_OFF_NS / CLK_NS;

   // Enable-low qualification before standby or sleep
   localparam int QUAL_MS  = 1;
   localparam int QUAL_CYC = QUAL_MS * (CLK_HZ / 1000);

   // Gate-bias ready time-out
   localparam int BIAS_TMO_MS  = 15;
   localparam int BIAS_TMO_CYC = BIAS_TMO_MS * (CLK_HZ / 1000);

   // Resume pin low time before a wake edge counts
   localparam int RESUME_LOW_US  = 10;
   localparam int RESUME_LOW_CYC = RESUME_LOW_US * (CLK_HZ / 1000000);

   // Timer counter width, holds the longest count
   localparam int TMR_W = 20;

   typedef enum logic [5:0] {
      ST_POR     = 6'h01,
      ST_LOGIC   = 6'h02,
      ST_BIAS    = 6'h04,
      ST_ACTIVE  = 6'h08,
      ST_STANDBY = 6'h10,
      ST_SLEEP   = 6'h20
   } gdpsc_state_e;

   localparam gdpsc_state_e RST_STATE = ST_POR;
   localparam logic [2:0]   GATES_OFF = 3'h0;

endpackage

// file: gdpsc_tmr_if.sv
`timescale 1ns/1ps
interface gdpsc_tmr_if;
   logic clr;
   logic run;
   logic done;

   modport ctrl (output clr, output run, input done);
   modport tmr  (input clr, input run, output done);
endinterface

// file: gdpsc_timer.sv
`timescale 1ns/1ps
module gdpsc_timer #(
   parameter int LIMIT = 1
) (
   input  wire logic  clk_i,     // Clock
   input  wire logic  reset_n_i, // Sync reset, active low
   gdpsc_tmr_if.tmr   t          // Restart, run and done
);

   logic [gdpsc_pkg::TMR_W-1:0] cnt_ff;
   logic [gdpsc_pkg::TMR_W-1:0] nxt_cnt;
   wire  [gdpsc_pkg::TMR_W-1:0] limit_w = gdpsc_pkg::TMR_W'(LIMIT);
   wire                         at_limit = (cnt_ff == limit_w);

   // Saturates so done stays up until the next restart
   assign nxt_cnt = t.clr ? '0
                  : (t.run && !at_limit) ? cnt_ff + 1'b1 : cnt_ff;
   assign t.done  = at_limit;

   always_ff @(posedge clk_i) begin
      if (!reset_n_i) begin
         cnt_ff <= '0;
      end else begin
         cnt_ff <= nxt_cnt;
      end
   end

endmodule

// file: gdpsc_host_model.sv
`timescale 1ns/1ps
module gdpsc_host_model #(
   parameter int PULSE_CYC = 14  // Fault-clear low pulse length
) (
   input  wire logic       clk_i,      // Clock
   input  wire logic       en_req_i,   // Wanted enable level
   input  wire logic       clr_req_i,  // Start a fault-clear pulse
   input  wire logic       rail_ok_i,  // Gate-bias rail charged
   input  wire logic [2:0] hi_req_i,   // Wanted high-side PWM
   input  wire logic [2:0] lo_req_i,   // Wanted low-side PWM
   output logic            drive_en_o, // Drive-enable pin
   output logic [2:0]      pwm_hi_o,   // High-side PWM pins
   output logic [2:0]      pwm_lo_o    // Low-side PWM pins
);
   int   pulse_cnt_ff = 0;
   logic rail_seen_ff = 1'b0;

   always @(negedge clk_i) begin
      if (clr_req_i && pulse_cnt_ff == 0)
         pulse_cnt_ff <= PULSE_CYC;
      else if (pulse_cnt_ff != 0)
         pulse_cnt_ff <= pulse_cnt_ff - 1;
      rail_seen_ff <= rail_ok_i & en_req_i;
   end

   assign drive_en_o = en_req_i && pulse_cnt_ff == 0;
   // PWM idle until the rail is charged
   assign pwm_hi_o = rail_seen_ff ? hi_req_i : 3'h0;
   assign pwm_lo_o = rail_seen_ff ? lo_req_i : 3'h0;
endmodule

// file: testbench.sv
`timescale 1ns/1ps
module testbench;
   localparam int QUAL  = 20;
   localparam int BIAS  = 50;
   localparam int PULSE = 14;
   logic       clk_i = 0, reset_n_i = 0, resume_i = 1, sleep_sel_i = 0;
   logic       fault_cond_i = 0, below_pump_th_i = 0, above_bypass_i = 0;
   logic       bias_rail_ok_i = 0, logic_rail_ok_i = 0;
   logic       en_req = 0, clr_req = 0;
   logic [2:0] hi_req = 3'h0, lo_req = 3'h0;
   logic       drive_en_i, err_flag_o, err_flag_oe_o, pump_en_o;
   logic       pump_bypass_o, bias_reg_en_o, logic_reg_en_o;
   logic       bias_ready_flag_o;
   logic [2:0] pwm_hi_i, pwm_lo_i, high_gate_out_o, low_gate_out_o;
   int         fail_count = 0, num_checks = 0;
   integer     seed = 74540;
   // Open-drain wire with external pull-up
   wire        err_flag_i = err_flag_oe_o ? err_flag_o : 1'b1;
   wire  [5:0] gates = {high_gate_out_o, low_gate_out_o};

   gdpsc_top #(.QUAL_CYC(QUAL), .BIAS_CYC(BIAS)) u_gdpsc_top (
      .clk_i, .reset_n_i, .drive_en_i, .resume_i, .sleep_sel_i,
      .pwm_hi_i, .pwm_lo_i, .fault_cond_i, .below_pump_th_i,
      .above_bypass_i, .bias_rail_ok_i, .logic_rail_ok_i, .err_flag_i,
      .err_flag_o, .err_flag_oe_o, .high_gate_out_o, .low_gate_out_o,
      .pump_en_o, .pump_bypass_o, .bias_reg_en_o, .logic_reg_en_o,
      .bias_ready_flag_o);
   gdpsc_host_model #(.PULSE_CYC(PULSE)) u_gdpsc_host_model (
      .clk_i, .en_req_i(en_req), .clr_req_i(clr_req),
      .rail_ok_i(bias_rail_ok_i), .hi_req_i(hi_req), .lo_req_i(lo_req),
      .drive_en_o(drive_en_i), .pwm_hi_o(pwm_hi_i), .pwm_lo_o(pwm_lo_i));

   initial forever #12.5 clk_i = ~clk_i;

   function automatic logic [5:0] exp_gates(input logic on);
      return on ? {hi_req, lo_req} : 6'h00;
   endfunction

   task automatic stop_test();
      $display("checks %0d mismatches %0d", num_checks, fail_count);
      if (fail_count == 0 && num_checks > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask

   task automatic cmp_bit(input logic got, input logic exp);
      num_checks++;
      if (got !== exp) begin
         fail_count++;
         $display("[ERR] %0t got %h exp %h", $time, got, exp);
      end
   endtask

   task automatic cmp_gate(input logic [5:0] exp);
      num_checks++;
      if (gates !== exp) begin
         fail_count++;
         $display("[ERR] %0t got %h exp %h", $time, gates, exp);
      end
   endtask

   task automatic cyc(input int n);
      repeat (n) @(negedge clk_i);
   endtask

   task automatic wait_ready();
      int i;
      for (i = 0; i < 200 && bias_ready_flag_o !== 1'b1; i++)
         cyc(1);
      if (i == 200) begin
         fail_count++;
         stop_test();
      end
   endtask

   task automatic pwm_rand();
      logic [31:0] r;
      r = $random(seed);
      {hi_req, lo_req} = r[5:0];
      cyc(3);
      cmp_gate(exp_gates(1'b1));
   endtask

   // Low pulse through the host; gates drop then show on_after
   task automatic pulse(input logic on_after);
      {hi_req, lo_req} = 6'h15;
      clr_req <= 1'b1;
      cyc(1);
      clr_req <= 1'b0;
      cyc(2);
      cmp_gate(6'h00);
      cyc(PULSE + 4);
      cmp_gate(exp_gates(on_after));
   endtask

   initial begin
      cyc(2);
      cmp_bit(err_flag_oe_o, 1'b1);
      cyc(2);
      reset_n_i = 1'b1;
      en_req <= 1'b1;
      cyc(5);
      cmp_bit(err_flag_i, 1'b0);
      logic_rail_ok_i = 1'b1;
      cyc(BIAS + 6);
      cmp_bit(bias_ready_flag_o, 1'b0);
      cmp_bit(err_flag_i, 1'b1);
      bias_rail_ok_i <= 1'b1;
      wait_ready();
      repeat (8) pwm_rand();
      cmp_bit(bias_reg_en_o, 1'b1);
      // Two close pulses: qualify count must restart
      pulse(1'b1);
      pulse(1'b1);
      cmp_bit(bias_reg_en_o, 1'b1);
      fault_cond_i = 1'b1;
      cyc(3);
      cmp_bit(err_flag_i, 1'b0);
      cmp_gate(6'h00);
      pulse(1'b0);
      fault_cond_i = 1'b0;
      cyc(3);
      cmp_bit(err_flag_i, 1'b0);
      pulse(1'b1);
      cmp_bit(err_flag_i, 1'b1);
      below_pump_th_i = 1'b1;
      cyc(3);
      cmp_bit(pump_en_o, 1'b1);
      cmp_bit(pump_bypass_o, 1'b0);
      above_bypass_i = 1'b1;
      cyc(3);
      cmp_bit(pump_en_o, 1'b0);
      cmp_bit(pump_bypass_o, 1'b1);
      above_bypass_i = 1'b0;
      en_req <= 1'b0;
      bias_rail_ok_i <= 1'b0;
      cyc(QUAL + 6);
      cmp_bit(bias_reg_en_o, 1'b0);
      cmp_bit(pump_en_o, 1'b0);
      cmp_bit(logic_reg_en_o, 1'b1);
      en_req <= 1'b1;
      cyc(3);
      cmp_bit(bias_reg_en_o, 1'b1);
      bias_rail_ok_i <= 1'b1;
      wait_ready();
      repeat (4) pwm_rand();
      fault_cond_i = 1'b1;
      sleep_sel_i = 1'b1;
      en_req <= 1'b0;
      bias_rail_ok_i <= 1'b0;
      cyc(QUAL + 6);
      cmp_bit(logic_reg_en_o, 1'b0);
      resume_i = 1'b0;
      cyc(10);
      resume_i = 1'b1;
      cyc(3);
      cmp_bit(logic_reg_en_o, 1'b0);
      resume_i = 1'b0;
      cyc(gdpsc_pkg::RESUME_LOW_CYC + 10);
      resume_i = 1'b1;
      cyc(4);
      cmp_bit(logic_reg_en_o, 1'b1);
      // Enable still low: standby after power-up, then sleep again
      cyc(3);
      cmp_bit(logic_reg_en_o, 1'b0);
      cmp_bit(err_flag_i, 1'b0);
      stop_test();
   end
endmodule
